// >>> logic/timer16_consts.svh
`ifndef TIMER16_CONSTS_SVH
`define TIMER16_CONSTS_SVH

// byte offsets on the 8-bit peripheral bus (4-bit address)
`define TMR_ADDR_FRC_HI   4'h0
`define TMR_ADDR_FRC_LO   4'h1
`define TMR_ADDR_OCR_HI   4'h2
`define TMR_ADDR_OCR_LO   4'h3
`define TMR_ADDR_CAPTURE_REG_A_HI  4'h4
`define TMR_ADDR_CAPTURE_REG_A_LO  4'h5
`define TMR_ADDR_CAPTURE_REG_B_HI  4'h6
`define TMR_ADDR_CAPTURE_REG_B_LO  4'h7
`define TMR_ADDR_CAPTURE_REG_C_HI  4'h8
`define TMR_ADDR_CAPTURE_REG_C_LO  4'h9
`define TMR_ADDR_CAPTURE_REG_D_HI  4'hA
`define TMR_ADDR_CAPTURE_REG_D_LO  4'hB
`define TMR_ADDR_STATUS   4'hC
`define TMR_ADDR_CTRL     4'hD
`define TMR_ADDR_OCTRL    4'hE
`define TMR_ADDR_IRQ_EN   4'hF

// reset values
`define TMR_CNT_RST       16'h0000
`define TMR_CMP_RST       16'hFFFF
`define TMR_CAP_RST       16'h0000
`define TMR_CTRL_RST      8'h00
`define TMR_OCTRL_RST     8'hE0
`define TMR_IRQ_EN_RST    8'h00
`define TMR_OCTRL_ONES    8'hE0

// timer_control fields
`define TMR_EDGE_A        7
`define TMR_EDGE_B        6
`define TMR_EDGE_C        5
`define TMR_EDGE_D        4
`define TMR_BUF_A         3
`define TMR_BUF_B         2
`define TMR_SRC_HI        1
`define TMR_SRC_LO        0

// compare_output_control fields
`define TMR_COMPARE_REG_SELECT          4
`define TMR_OE_A          3
`define TMR_OE_B          2
`define TMR_LVL_A         1
`define TMR_LVL_B         0

// status: flags sit in bits 7..1, clear_on_match_a in bit 0
`define TMR_CLR_A         0

// prescaler tap bits for /2, /8 and /32
`define TMR_TAP_DIV2      0
`define TMR_TAP_DIV8      2
`define TMR_TAP_DIV32     4

`endif

// >>> logic/timer16_pkg.sv
`default_nettype none

package timer16_pkg;

  typedef enum logic [1:0] {
    SRC_DIV2,
    SRC_DIV8,
    SRC_DIV32,
    SRC_EXT
  } count_src_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } pin_sync_state_t;

  typedef struct packed {
    logic [15:0] free_running_counter;
    logic [15:0] compare_reg_a;
    logic [15:0] compare_reg_b;
    logic [15:0] capture_reg_a;
    logic [15:0] capture_reg_b;
    logic [15:0] capture_reg_c;
    logic [15:0] capture_reg_d;
    logic [7:0]  byte_latch;
    logic [7:0]  timer_control;
    logic [7:0]  compare_output_control;
    logic [7:0]  interrupt_enable_reg;
    logic [7:0]  rdata;
    logic [6:0]  flags;
    logic [6:0]  flags_seen;
    logic        clear_on_match_a;
    logic [4:0]  prescale;
    logic        src_level;
    logic        out_level_a;
    logic        out_level_b;
    logic [3:0]  cap_pending;
  } timer_state_t;

endpackage

`default_nettype wire

// >>> logic/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none

// three-stage synchroniser; a change is taken once stages two and three agree
module pin_sync (
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output logic      rise_o,
  output logic      fall_o
);

  timer16_pkg::pin_sync_state_t st;
  timer16_pkg::pin_sync_state_t next_st;

  // s1 feeds only s2; the agreement check looks at s2 and s3
  always_comb begin
    next_st = st;
    next_st.s1 = pin_i;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    if (st.s2 == st.s3) begin
      next_st.level = st.s3;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // one-cycle pulses on the accepted change
  assign rise_o = (st.s2 & st.s3) & ~st.level;
  assign fall_o = ~(st.s2 | st.s3) & st.level;

endmodule

`default_nettype wire

// >>> logic/capture_compare_timer16.sv
`timescale 1ns/10ps
`default_nettype none
`include "timer16_consts.svh"

// Notes on behaviour
// - two select bits pick /2, /8, /32, external
// - external clock counts rising edges; each level must be sampled on two successive clocks
// - output control resets to E0, also low-power
// - output control top three bits read one
// - shared compare address, bit 4 picks A/B
// - bits 3/2 enable compare pins A/B
// - bits 1/0 give match level for A/B
// - one shared byte latch for 16-bit registers
// - upper write to latch, lower write commits both
// - upper read of counter/capture latches lower byte
// - compare registers read directly, no latch
// - counter starts at zero and counts up
// - match drives pin level from level bit
// - compare pins low until first match
// - clear-on-match-A zeroes counter on match A
// - capture edge copies counter, flags, requests interrupt
// - buffered pair shifts A/B into C/D
// - edge select: zero falling, one rising
// - flags hardware-set, cleared by read-1 write-0
// - wrap from FFFF to 0000 sets wrap flag
// - buffer bit makes C/D hold previous capture
module capture_compare_timer16 #(
  parameter int CNT_W = 16
) (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic       low_power_i,
  input  wire logic [3:0] addr_i,
  input  wire logic       rd_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o,
  input  wire logic       ext_clk_i,
  input  wire logic       capture_pin_a_i,
  input  wire logic       capture_pin_b_i,
  input  wire logic       capture_pin_c_i,
  input  wire logic       capture_pin_d_i,
  output logic            compare_pin_a_o,
  output logic            compare_pin_a_en_o,
  output logic            compare_pin_b_o,
  output logic            compare_pin_b_en_o,
  output logic            irq_o
);

  // the byte path splits every wide register in exactly two halves
  if (CNT_W != 16) begin : g_width_check
    $error("capture_compare_timer16 supports CNT_W of 16 only");
  end

  localparam timer16_pkg::timer_state_t RESET_STATE = '{
    free_running_counter:   `TMR_CNT_RST,
    compare_reg_a:          `TMR_CMP_RST,
    compare_reg_b:          `TMR_CMP_RST,
    capture_reg_a:          `TMR_CAP_RST,
    capture_reg_b:          `TMR_CAP_RST,
    capture_reg_c:          `TMR_CAP_RST,
    capture_reg_d:          `TMR_CAP_RST,
    timer_control:          `TMR_CTRL_RST,
    compare_output_control: `TMR_OCTRL_RST,
    interrupt_enable_reg:   `TMR_IRQ_EN_RST,
    default:                '0
  };

  timer16_pkg::timer_state_t st;
  timer16_pkg::timer_state_t next_st;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [4:0] pin_rise;
  logic [4:0] pin_fall;
  logic [4:0] pin_raw;

  assign pin_raw = {ext_clk_i, capture_pin_a_i, capture_pin_b_i,
                    capture_pin_c_i, capture_pin_d_i};

  // index 4 external clock, 3..0 capture A..D
  for (genvar i = 0; i < 5; i++) begin : g_sync
    pin_sync u_sync (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .pin_i     (pin_raw[i]),
      .rise_o    (pin_rise[i]),
      .fall_o    (pin_fall[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  timer16_pkg::count_src_t src;
  logic       sel_level;
  logic       inc;
  logic       cmp_wr_a;
  logic       cmp_wr_b;
  logic       match_a;
  logic       match_b;
  logic       frc_lo_wr;
  logic       counter_clear;
  logic       wrap;
  logic [3:0] cap_edge;
  logic [3:0] cap_block;
  logic [3:0] cap_fire;
  logic [6:0] flag_set;
  logic [6:0] flag_clr;
  logic       rd_hi_a;
  logic       rd_hi_b;
  logic       rd_hi_c;
  logic       rd_hi_d;
  logic       buf_a;
  logic       buf_b;
  logic       sel_b;

  always_comb begin
    next_st = st;
    src = timer16_pkg::count_src_t'(st.timer_control[`TMR_SRC_HI:`TMR_SRC_LO]);
    buf_a = st.timer_control[`TMR_BUF_A];
    buf_b = st.timer_control[`TMR_BUF_B];
    sel_b = st.compare_output_control[`TMR_COMPARE_REG_SELECT];

    // count source; a switch that looks like a falling edge counts
    next_st.prescale = st.prescale + 5'h01;
    case (src)
      timer16_pkg::SRC_DIV2:  sel_level = st.prescale[`TMR_TAP_DIV2];
      timer16_pkg::SRC_DIV8:  sel_level = st.prescale[`TMR_TAP_DIV8];
      timer16_pkg::SRC_DIV32: sel_level = st.prescale[`TMR_TAP_DIV32];
      default:                sel_level = 1'b0;
    endcase
    next_st.src_level = sel_level;
    if (src == timer16_pkg::SRC_EXT) begin
      inc = pin_rise[4];
    end else begin
      inc = st.src_level & ~sel_level;
    end

    // a lower-byte compare write inhibits that channel's match
    cmp_wr_a = wr_i && addr_i == `TMR_ADDR_OCR_LO && !sel_b;
    cmp_wr_b = wr_i && addr_i == `TMR_ADDR_OCR_LO && sel_b;
    frc_lo_wr = wr_i && addr_i == `TMR_ADDR_FRC_LO;

    // match fires as the counter leaves the matching value
    match_a = inc && st.free_running_counter == st.compare_reg_a
              && !cmp_wr_a;
    match_b = inc && st.free_running_counter == st.compare_reg_b
              && !cmp_wr_b;
    counter_clear = match_a && st.clear_on_match_a;

    // clear beats a write, a write beats an increment
    wrap = 1'b0;
    if (counter_clear) begin
      next_st.free_running_counter = `TMR_CNT_RST;
    end else if (frc_lo_wr) begin
      next_st.free_running_counter = {st.byte_latch, wdata_i};
    end else if (inc) begin
      next_st.free_running_counter =
        st.free_running_counter + 16'h0001;
      wrap = st.free_running_counter == 16'hFFFF;
    end

    // compare levels track matches whether or not the pin is enabled
    if (match_a) begin
      next_st.out_level_a = st.compare_output_control[`TMR_LVL_A];
    end
    if (match_b) begin
      next_st.out_level_b = st.compare_output_control[`TMR_LVL_B];
    end

    // capture edges, 0 falling and 1 rising
    cap_edge[3] = st.timer_control[`TMR_EDGE_A] ? pin_rise[3]
                                                : pin_fall[3];
    cap_edge[2] = st.timer_control[`TMR_EDGE_B] ? pin_rise[2]
                                                : pin_fall[2];
    cap_edge[1] = st.timer_control[`TMR_EDGE_C] ? pin_rise[1]
                                                : pin_fall[1];
    cap_edge[0] = st.timer_control[`TMR_EDGE_D] ? pin_rise[0]
                                                : pin_fall[0];

    // an upper-byte read of a receiving register delays capture a cycle
    rd_hi_a = rd_i && addr_i == `TMR_ADDR_CAPTURE_REG_A_HI;
    rd_hi_b = rd_i && addr_i == `TMR_ADDR_CAPTURE_REG_B_HI;
    rd_hi_c = rd_i && addr_i == `TMR_ADDR_CAPTURE_REG_C_HI;
    rd_hi_d = rd_i && addr_i == `TMR_ADDR_CAPTURE_REG_D_HI;
    cap_block[3] = rd_hi_a || (buf_a && rd_hi_c);
    cap_block[2] = rd_hi_b || (buf_b && rd_hi_d);
    cap_block[1] = rd_hi_c || (buf_a && rd_hi_a);
    cap_block[0] = rd_hi_d || (buf_b && rd_hi_b);
    cap_fire = (cap_edge | st.cap_pending) & ~cap_block;
    next_st.cap_pending = (cap_edge | st.cap_pending) & cap_block;

    // capture transfers; buffered C/D only shift, never take the counter
    if (cap_fire[3]) begin
      next_st.capture_reg_a = st.free_running_counter;
      if (buf_a) begin
        next_st.capture_reg_c = st.capture_reg_a;
      end
    end
    if (cap_fire[2]) begin
      next_st.capture_reg_b = st.free_running_counter;
      if (buf_b) begin
        next_st.capture_reg_d = st.capture_reg_b;
      end
    end
    if (cap_fire[1] && !buf_a) begin
      next_st.capture_reg_c = st.free_running_counter;
    end
    if (cap_fire[0] && !buf_b) begin
      next_st.capture_reg_d = st.free_running_counter;
    end

    // flag order: cap A..D, match A, match B, wrap
    flag_set = {cap_fire, match_a, match_b, wrap};
    flag_clr = 7'h00;
    if (wr_i && addr_i == `TMR_ADDR_STATUS) begin
      flag_clr = st.flags_seen & ~wdata_i[7:1];
      next_st.flags_seen = 7'h00;
      next_st.clear_on_match_a = wdata_i[`TMR_CLR_A];
    end
    // a set in the clearing cycle survives
    next_st.flags = (st.flags & ~flag_clr) | flag_set;

    // register writes; capture registers are read-only
    if (wr_i) begin
      case (addr_i)
        `TMR_ADDR_FRC_HI,
        `TMR_ADDR_OCR_HI: next_st.byte_latch = wdata_i;
        `TMR_ADDR_OCR_LO: begin
          if (sel_b) begin
            next_st.compare_reg_b = {st.byte_latch, wdata_i};
          end else begin
            next_st.compare_reg_a = {st.byte_latch, wdata_i};
          end
        end
        `TMR_ADDR_CTRL:   next_st.timer_control = wdata_i;
        `TMR_ADDR_OCTRL:
          next_st.compare_output_control = wdata_i | `TMR_OCTRL_ONES;
        `TMR_ADDR_IRQ_EN: next_st.interrupt_enable_reg = wdata_i;
        default: ;
      endcase
    end

    // register reads; data appears on the following cycle
    if (rd_i) begin
      case (addr_i)
        `TMR_ADDR_FRC_HI: begin
          next_st.rdata = st.free_running_counter[15:8];
          next_st.byte_latch = st.free_running_counter[7:0];
        end
        `TMR_ADDR_CAPTURE_REG_A_HI: begin
          next_st.rdata = st.capture_reg_a[15:8];
          next_st.byte_latch = st.capture_reg_a[7:0];
        end
        `TMR_ADDR_CAPTURE_REG_B_HI: begin
          next_st.rdata = st.capture_reg_b[15:8];
          next_st.byte_latch = st.capture_reg_b[7:0];
        end
        `TMR_ADDR_CAPTURE_REG_C_HI: begin
          next_st.rdata = st.capture_reg_c[15:8];
          next_st.byte_latch = st.capture_reg_c[7:0];
        end
        `TMR_ADDR_CAPTURE_REG_D_HI: begin
          next_st.rdata = st.capture_reg_d[15:8];
          next_st.byte_latch = st.capture_reg_d[7:0];
        end
        `TMR_ADDR_FRC_LO,
        `TMR_ADDR_CAPTURE_REG_A_LO,
        `TMR_ADDR_CAPTURE_REG_B_LO,
        `TMR_ADDR_CAPTURE_REG_C_LO,
        `TMR_ADDR_CAPTURE_REG_D_LO: next_st.rdata = st.byte_latch;
        `TMR_ADDR_OCR_HI:
          next_st.rdata = sel_b ? st.compare_reg_b[15:8]
                                : st.compare_reg_a[15:8];
        `TMR_ADDR_OCR_LO:
          next_st.rdata = sel_b ? st.compare_reg_b[7:0]
                                : st.compare_reg_a[7:0];
        `TMR_ADDR_STATUS: begin
          next_st.rdata = {st.flags, st.clear_on_match_a};
          next_st.flags_seen = st.flags;
        end
        `TMR_ADDR_CTRL:   next_st.rdata = st.timer_control;
        `TMR_ADDR_OCTRL:
          next_st.rdata = st.compare_output_control | `TMR_OCTRL_ONES;
        `TMR_ADDR_IRQ_EN: next_st.rdata = st.interrupt_enable_reg;
        default:          next_st.rdata = 8'h00;
      endcase
    end

    // low-power modes reset every register as reset does, except the pin synchronisers, which only reset clears
    if (low_power_i) begin
      next_st = RESET_STATE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st <= RESET_STATE;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign rdata_o = st.rdata;
  // levels start at 0 and move only on a match or back to 0 in low power
  assign compare_pin_a_o = st.out_level_a;
  assign compare_pin_b_o = st.out_level_b;
  // when low the pin goes back to its port function
  assign compare_pin_a_en_o =
    st.compare_output_control[`TMR_OE_A];
  assign compare_pin_b_en_o =
    st.compare_output_control[`TMR_OE_B];
  // one shared request line; software tells sources apart by flag
  assign irq_o = |(st.flags & st.interrupt_enable_reg[7:1]);

endmodule

`default_nettype wire

// >>> verif/timer16_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "timer16_consts.svh"

module timer16_checker (
  input wire logic       ref_clk_i,
  input wire logic       rst_i,
  input wire logic       low_power_i,
  input wire logic [3:0] addr_i,
  input wire logic       rd_i,
  input wire logic       wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic       compare_pin_a_o,
  input wire logic       compare_pin_a_en_o,
  input wire logic       compare_pin_b_o,
  input wire logic       compare_pin_b_en_o,
  input wire logic       irq_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  logic [4:0] oc_q;
  logic       oc_wr;

  // shadow of the writable output-control bits; low power drops it too
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || low_power_i) begin
      oc_q <= 5'h00;
    end else if (oc_wr) begin
      oc_q <= wdata_i[4:0];
    end
  end
  assign oc_wr = wr_i && addr_i == `TMR_ADDR_OCTRL && !low_power_i;

  ////////////////////////////////////////////////////////////////////////////
  en_pin_a_a: assert property (oc_wr |=>
    compare_pin_a_en_o == $past(wdata_i[3])) else $error("pin a enable");
  en_pin_b_a: assert property (oc_wr |=>
    compare_pin_b_en_o == $past(wdata_i[2])) else $error("pin b enable");
  reset_outputs_a: assert property ($fell(rst_i) |-> rdata_o == 8'h00 &&
    !compare_pin_a_o && !compare_pin_b_o && !compare_pin_a_en_o &&
    !compare_pin_b_en_o && !irq_o) else $error("outputs after reset");
  ctrl_readback_a: assert property (
    rd_i && addr_i == `TMR_ADDR_OCTRL && !low_power_i |=>
    rdata_o == {3'h7, $past(oc_q)}) else $error("control readback");
  low_power_clear_a: assert property (low_power_i |=>
    !compare_pin_a_en_o && !compare_pin_b_en_o && !compare_pin_a_o &&
    !compare_pin_b_o && !irq_o) else $error("low power clear");
  // a pin may only move to the level its control bit held at the match
  level_pin_a_a: assert property (
    !$past(low_power_i) && $changed(compare_pin_a_o) |->
    compare_pin_a_o == $past(oc_q[1])) else $error("pin a level");
  level_pin_b_a: assert property (
    !$past(low_power_i) && $changed(compare_pin_b_o) |->
    compare_pin_b_o == $past(oc_q[0])) else $error("pin b level");
  irq_masked_a: assert property (
    wr_i && addr_i == `TMR_ADDR_IRQ_EN && wdata_i == 8'h00 |=> !irq_o)
    else $error("irq while masked");

  cover property ($rose(compare_pin_a_o));
  cover property ($rose(compare_pin_b_o));
  cover property ($rose(irq_o));
  cover property (low_power_i ##1 !low_power_i);
endmodule

bind capture_compare_timer16 timer16_checker i_timer16_checker (
  .ref_clk_i, .rst_i, .low_power_i, .addr_i, .rd_i, .wr_i, .wdata_i,
  .rdata_o, .compare_pin_a_o, .compare_pin_a_en_o, .compare_pin_b_o,
  .compare_pin_b_en_o, .irq_o);

`default_nettype wire

// >>> verif/cpu_bus_model.sv
`timescale 1ns/10ps
`default_nettype none

module cpu_bus_model (
  input  wire logic       ref_clk_i,
  input  wire logic [7:0] rdata_i,
  output logic      [3:0] addr_o,
  output logic            rd_o,
  output logic            wr_o,
  output logic      [7:0] wdata_o
);
  initial begin
    addr_o = 4'h0;
    rd_o = 1'b0;
    wr_o = 1'b0;
    wdata_o = 8'h00;
  end

  // one strobe per access, launched and dropped on the falling edge;
  // an idle bus shows the inverse, never the last value
  task automatic wr8(input logic [3:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge ref_clk_i);
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask

  // read data is registered, so it is taken one edge after the strobe
  task automatic rd8(input logic [3:0] a, output logic [7:0] d);
    @(negedge ref_clk_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge ref_clk_i);
    rd_o = 1'b0;
    d = rdata_i;
    addr_o = ~a;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // 16-bit values always go upper byte first
  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    wr8(a, v[15:8]);
    wr8(a + 4'h1, v[7:0]);
  endtask

  task automatic rd16(input logic [3:0] a, output logic [15:0] v);
    rd8(a, v[15:8]);
    rd8(a + 4'h1, v[7:0]);
  endtask
endmodule

`default_nettype wire

// >>> verif/capture_compare_timer16_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "timer16_consts.svh"

module capture_compare_timer16_tb_top;
  typedef struct {
    logic [3:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } row_t;

  logic        ref_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        low_power_i = 1'b0;
  logic        ext_clk_i = 1'b0;
  logic [3:0]  cap = 4'h0;
  logic [3:0]  addr_i;
  logic        rd_i;
  logic        wr_i;
  logic [7:0]  wdata_i;
  logic [7:0]  rdata_o;
  logic        pa;
  logic        ea;
  logic        pb;
  logic        eb;
  logic        irq_o;
  logic [7:0]  b;
  logic [15:0] v;
  logic [15:0] w;
  int          n_mismatch = 0;
  int          n_compared = 0;
  row_t        rows [7] = '{
    '{`TMR_ADDR_OCTRL, 8'hFF, 8'hFF}, '{`TMR_ADDR_OCTRL, 8'h00, 8'hE0},
    '{`TMR_ADDR_CTRL, 8'hF3, 8'hF3}, '{`TMR_ADDR_CTRL, 8'h00, 8'h00},
    '{`TMR_ADDR_IRQ_EN, 8'h00, 8'h00}, '{`TMR_ADDR_CAPTURE_REG_A_HI, 8'h12, 8'h00},
    '{`TMR_ADDR_CAPTURE_REG_D_LO, 8'h34, 8'h00}};

  initial begin
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  capture_compare_timer16 i_capture_compare_timer16 (
    .ref_clk_i, .rst_i, .low_power_i, .addr_i, .rd_i, .wr_i, .wdata_i,
    .rdata_o, .ext_clk_i, .capture_pin_a_i(cap[0]),
    .capture_pin_b_i(cap[1]), .capture_pin_c_i(cap[2]),
    .capture_pin_d_i(cap[3]), .compare_pin_a_o(pa),
    .compare_pin_a_en_o(ea), .compare_pin_b_o(pb),
    .compare_pin_b_en_o(eb), .irq_o);

  cpu_bus_model i_cpu_bus_model (
    .ref_clk_i, .rdata_i(rdata_o), .addr_o(addr_i), .rd_o(rd_i),
    .wr_o(wr_i), .wdata_o(wdata_i));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // pulses stay 4 clocks wide, well above the minimum width
  task automatic pulses(input int n);
    repeat (n) begin
      @(negedge ref_clk_i);
      ext_clk_i = 1'b1;
      repeat (4) @(negedge ref_clk_i);
      ext_clk_i = 1'b0;
      repeat (4) @(negedge ref_clk_i);
    end
    repeat (4) @(negedge ref_clk_i);
  endtask

  task automatic edge_a(input logic lvl);
    @(negedge ref_clk_i);
    cap[0] = lvl;
    repeat (8) @(negedge ref_clk_i);
  endtask

  // a hang counts as a mismatch and still reaches the report
  initial begin
    repeat (60000) @(posedge ref_clk_i);
    n_mismatch++;
    results();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(negedge ref_clk_i);
    rst_i = 1'b0;
    i_cpu_bus_model.rd8(`TMR_ADDR_OCTRL, b);
    check(16'(b), 16'h00E0);
    i_cpu_bus_model.rd16(`TMR_ADDR_OCR_HI, v);
    check(v, 16'hFFFF);
    foreach (rows[i]) begin
      i_cpu_bus_model.wr8(rows[i].a, rows[i].d);
      i_cpu_bus_model.rd8(rows[i].a, b);
      check(16'(b), 16'(rows[i].e));
    end
    // hi reads 4*div clocks apart must differ by exactly four counts
    for (int s = 0; s < 3; s++) begin
      i_cpu_bus_model.wr8(`TMR_ADDR_CTRL, 8'(s));
      i_cpu_bus_model.rd16(`TMR_ADDR_FRC_HI, v);
      repeat ((8 << (2 * s)) - 4) @(negedge ref_clk_i);
      i_cpu_bus_model.rd16(`TMR_ADDR_FRC_HI, w);
      check(16'(w - v), 16'h0004);
    end
    // external source with a quiet pin freezes the counter
    i_cpu_bus_model.wr8(`TMR_ADDR_CTRL, 8'h03);
    i_cpu_bus_model.wr16(`TMR_ADDR_FRC_HI, 16'hAA55);
    i_cpu_bus_model.rd16(`TMR_ADDR_FRC_HI, v);
    check(v, 16'hAA55);
    pulses(3);
    i_cpu_bus_model.rd16(`TMR_ADDR_FRC_HI, v);
    check(v, 16'hAA58);
    i_cpu_bus_model.wr16(`TMR_ADDR_OCR_HI, 16'h0005);
    i_cpu_bus_model.wr8(`TMR_ADDR_OCTRL, 8'h0A);
    check(16'({ea, eb}), 16'h0002);
    i_cpu_bus_model.wr16(`TMR_ADDR_FRC_HI, 16'h0004);
    pulses(1);
    check(16'(pa), 16'h0000);
    pulses(1);
    check(16'(pa), 16'h0001);
    i_cpu_bus_model.rd8(`TMR_ADDR_STATUS, b);
    check(16'(b), 16'h0008);
    i_cpu_bus_model.wr8(`TMR_ADDR_STATUS, 8'h00);
    i_cpu_bus_model.wr8(`TMR_ADDR_STATUS, 8'hFE);
    i_cpu_bus_model.rd8(`TMR_ADDR_STATUS, b);
    check(16'(b), 16'h0000);
    // second register through the shared address
    i_cpu_bus_model.wr8(`TMR_ADDR_OCTRL, 8'h15);
    i_cpu_bus_model.wr16(`TMR_ADDR_OCR_HI, 16'h0007);
    i_cpu_bus_model.wr8(`TMR_ADDR_OCTRL, 8'h05);
    i_cpu_bus_model.rd16(`TMR_ADDR_OCR_HI, v);
    check(v, 16'h0005);
    i_cpu_bus_model.wr8(`TMR_ADDR_OCTRL, 8'h15);
    i_cpu_bus_model.rd16(`TMR_ADDR_OCR_HI, v);
    check(v, 16'h0007);
    check(16'({pa, ea, pb, eb}), 16'h0009);
    pulses(1);
    check(16'(pb), 16'h0000);
    pulses(1);
    check(16'(pb), 16'h0001);
    // clear on match A, then wrap
    i_cpu_bus_model.wr8(`TMR_ADDR_STATUS, 8'h01);
    i_cpu_bus_model.wr16(`TMR_ADDR_FRC_HI, 16'h0004);
    pulses(2);
    i_cpu_bus_model.rd16(`TMR_ADDR_FRC_HI, v);
    check(v, 16'h0000);
    // pin A disabled and level A low: the level still follows the match
    check(16'({pa, ea}), 16'h0000);
    i_cpu_bus_model.rd8(`TMR_ADDR_STATUS, b);
    check(16'(b), 16'h000D);
    i_cpu_bus_model.wr8(`TMR_ADDR_STATUS, 8'h00);
    i_cpu_bus_model.wr16(`TMR_ADDR_FRC_HI, 16'hFFFF);
    pulses(1);
    i_cpu_bus_model.rd8(`TMR_ADDR_STATUS, b);
    check(16'(b), 16'h0002);
    // capture on the rising edge only
    i_cpu_bus_model.wr16(`TMR_ADDR_FRC_HI, 16'h1234);
    i_cpu_bus_model.wr8(`TMR_ADDR_CTRL, 8'h83);
    i_cpu_bus_model.wr8(`TMR_ADDR_IRQ_EN, 8'h80);
    check(16'(irq_o), 16'h0000);
    edge_a(1'b1);
    i_cpu_bus_model.rd16(`TMR_ADDR_CAPTURE_REG_A_HI, v);
    check(v, 16'h1234);
    check(16'(irq_o), 16'h0001);
    i_cpu_bus_model.wr16(`TMR_ADDR_FRC_HI, 16'h2222);
    edge_a(1'b0);
    i_cpu_bus_model.rd16(`TMR_ADDR_CAPTURE_REG_A_HI, v);
    check(v, 16'h1234);
    // buffered pair moves the old capture into C
    i_cpu_bus_model.wr8(`TMR_ADDR_CTRL, 8'h8B);
    i_cpu_bus_model.wr16(`TMR_ADDR_FRC_HI, 16'h5678);
    edge_a(1'b1);
    i_cpu_bus_model.rd16(`TMR_ADDR_CAPTURE_REG_A_HI, v);
    check(v, 16'h5678);
    i_cpu_bus_model.rd16(`TMR_ADDR_CAPTURE_REG_C_HI, v);
    check(v, 16'h1234);
    // a C edge while C buffers A only raises flag C
    @(negedge ref_clk_i);
    cap[2] = 1'b1;
    repeat (8) @(negedge ref_clk_i);
    cap[2] = 1'b0;
    repeat (8) @(negedge ref_clk_i);
    i_cpu_bus_model.rd16(`TMR_ADDR_CAPTURE_REG_C_HI, v);
    check(v, 16'h1234);
    i_cpu_bus_model.rd8(`TMR_ADDR_STATUS, b);
    check(16'(b), 16'h00A2);
    // low power returns the output-control register to its reset value
    i_cpu_bus_model.wr8(`TMR_ADDR_OCTRL, 8'h1F);
    @(negedge ref_clk_i);
    low_power_i = 1'b1;
    @(negedge ref_clk_i);
    low_power_i = 1'b0;
    i_cpu_bus_model.rd8(`TMR_ADDR_OCTRL, b);
    check(16'(b), 16'h00E0);
    check(16'({ea, eb, irq_o}), 16'h0000);
    // a mid-run reset drops a frozen counter back to zero
    i_cpu_bus_model.wr8(`TMR_ADDR_CTRL, 8'h03);
    i_cpu_bus_model.wr16(`TMR_ADDR_FRC_HI, 16'hAA55);
    @(negedge ref_clk_i);
    rst_i = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    rst_i = 1'b0;
    i_cpu_bus_model.rd16(`TMR_ADDR_FRC_HI, v);
    check(v, 16'h0000);
    results();
  end
endmodule

`default_nettype wire
